// file: design/spc_counter.sv
// Presettable decade or binary counter with a register bus view
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
module spc_counter #(
    parameter bit DECADE = 1'b1
) (
    // Clock and resets
    input  wire logic                      sys_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      master_clear_n,
    // Counter controls and preset data
    input  wire spc_pkg::spc_ctrl_t        ctrl,
    input  wire logic [3:0]                preset_value,
    // Counter outputs
    output logic [3:0]                     count_state,
    output logic                           terminal_flag,
    // Avalon-MM slave
    input  wire logic [spc_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest
);

    // ------------------------------------------------------------
    // Mode decode and next state
    // ------------------------------------------------------------
    logic [3:0] state_r;
    logic [3:0] state_nxt;
    logic [3:0] max_state;
    logic       load_now;
    logic       count_now;
    logic       at_max;
    logic [3:0] bit_match;

    assign max_state = DECADE ? spc_pkg::DEC_MAX : spc_pkg::BIN_MAX;
    assign load_now  = !ctrl.load_enable_n;
    assign count_now = ctrl.parallel_count_enable
                     && ctrl.trickle_count_enable;

    // Full four-bit compare, so 13 or 11 never look like 9
    for (genvar b = 0; b < spc_pkg::STATE_W; b++) begin : g_match
        assign bit_match[b] = (state_r[b] == max_state[b]);
    end
    assign at_max    = &bit_match;

    // ------------------------------------------------------------
    // Operating mode in fixed priority below the clear
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_HOLD  = 2'b00,
        MODE_COUNT = 2'b01,
        MODE_LOAD  = 2'b10
    } spc_mode_t;

    spc_mode_t mode;

    always_comb begin
        if (load_now) begin
            mode = MODE_LOAD;
        end else if (count_now) begin
            mode = MODE_COUNT;
        end else begin
            mode = MODE_HOLD;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (mode)
            MODE_LOAD: begin
                state_nxt = preset_value;
            end
            MODE_COUNT: begin
                if (DECADE && state_r >= spc_pkg::DEC_MAX) begin
                    // Also folds 10..15 straight back to zero
                    state_nxt = spc_pkg::STATE_RST;
                end else begin
                    state_nxt = 4'(state_r + 4'h1);
                end
            end
            MODE_HOLD: begin
                state_nxt = state_r;
            end
            default: begin
                // Code 2'b11 is never decoded; hold rather than guess
                state_nxt = state_r;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Edge-triggered, so enables may move freely between edges
    always_ff @(posedge sys_clk or posedge sys_rst
                or negedge master_clear_n) begin
        if (sys_rst || !master_clear_n) begin
            state_r <= spc_pkg::STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign count_state = state_r;
    // Combinational by necessity: it must follow trickle enable at once
    assign terminal_flag = ctrl.trickle_count_enable && at_max;

    // ------------------------------------------------------------
    // Register bus slave, one wait state per access
    // ------------------------------------------------------------
    logic [3:0]  capture_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_mux;
    logic        req;

    assign req = avs_read || avs_write;

    always_comb begin
        rd_mux = spc_pkg::RD_ZERO;
        if (avs_address == spc_pkg::OFS_STATUS) begin
            rd_mux[3:0]                 = state_r;
            rd_mux[spc_pkg::ST_TC_BIT]  = terminal_flag;
            rd_mux[spc_pkg::ST_DEC_BIT] = DECADE;
        end else if (avs_address == spc_pkg::OFS_CAPTURE) begin
            rd_mux[3:0] = capture_r;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !(req && wait_r);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= spc_pkg::RD_ZERO;
        end else if (avs_read && wait_r) begin
            rdata_r <= rd_mux;
        end
    end

    // A write to the capture offset with lane 0 set snapshots the live count
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            capture_r <= spc_pkg::STATE_RST;
        end else if (avs_write && !wait_r && avs_byteenable[0]
                     && avs_address == spc_pkg::OFS_CAPTURE) begin
            capture_r <= state_r;
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    clear_forces_zero_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !master_clear_n |-> count_state == 4'h0)
        else $error("state not zero under master clear");

    load_copies_preset_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        !ctrl.load_enable_n |=> count_state == $past(preset_value))
        else $error("preset not loaded");

    load_beats_count_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        (!ctrl.load_enable_n && ctrl.parallel_count_enable
         && ctrl.trickle_count_enable)
        |=> count_state == $past(preset_value))
        else $error("count overrode load");

    hold_when_idle_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        (ctrl.load_enable_n && !(ctrl.parallel_count_enable
         && ctrl.trickle_count_enable)) |=> $stable(count_state))
        else $error("state moved while held");

    count_steps_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        (ctrl.load_enable_n && count_now && count_state < max_state)
        |=> count_state == $past(count_state) + 4'h1)
        else $error("count did not advance by one");

    max_wraps_zero_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        (ctrl.load_enable_n && count_now && count_state == max_state)
        |=> count_state == 4'h0)
        else $error("maximum did not wrap to zero");

    terminal_decode_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        terminal_flag == (ctrl.trickle_count_enable
                          && count_state == max_state))
        else $error("terminal flag decode wrong");

    illegal_recover_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        (DECADE && count_state > 4'h9 && ctrl.load_enable_n && count_now)
        |=> count_state <= 4'h9)
        else $error("decade did not leave illegal state");

    full_decode_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        terminal_flag |-> (DECADE
            ? (count_state[0] && !count_state[1]
               && !count_state[2] && count_state[3])
            : (&count_state)))
        else $error("terminal flag on a partial decode");

    trickle_gates_flag_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !ctrl.trickle_count_enable |-> !terminal_flag)
        else $error("terminal flag without trickle enable");

    decade_stays_legal_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        (DECADE && ctrl.load_enable_n && count_state <= 4'h9)
        |=> count_state <= 4'h9)
        else $error("decade count left zero to nine");

    load_ignores_enables_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst || !master_clear_n)
        (!ctrl.load_enable_n && !ctrl.parallel_count_enable
         && !ctrl.trickle_count_enable)
        |=> count_state == $past(preset_value))
        else $error("load depended on count enables");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    bus_one_wait_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    idle_wait_high_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !req |=> avs_waitrequest)
        else $error("waitrequest low without a request");

    status_decade_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (avs_read && avs_waitrequest && avs_address == spc_pkg::OFS_STATUS)
        |=> avs_readdata[spc_pkg::ST_DEC_BIT] == DECADE)
        else $error("status build bit wrong");

    status_state_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (avs_read && avs_waitrequest && avs_address == spc_pkg::OFS_STATUS)
        |=> avs_readdata[3:0] == $past(count_state))
        else $error("status count field wrong");

    readdata_holds_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved between reads");

    unmapped_reads_zero_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (avs_read && avs_waitrequest && avs_address != spc_pkg::OFS_STATUS
         && avs_address != spc_pkg::OFS_CAPTURE)
        |=> avs_readdata == spc_pkg::RD_ZERO)
        else $error("unmapped read not zero");

    capture_lane_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (avs_write && !avs_byteenable[0]) |=> $stable(capture_r))
        else $error("capture taken without lane 0");

    capture_snapshot_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (avs_write && !avs_waitrequest && avs_byteenable[0]
         && avs_address == spc_pkg::OFS_CAPTURE)
        |=> capture_r == $past(count_state))
        else $error("capture did not take the count");

endmodule

// file: design/spc_pkg.sv
// Constants and carrier types for the presettable four-bit counter
package spc_pkg;
    // ------------------------------------------------------------
    // Counter geometry and decode points
    // ------------------------------------------------------------
    localparam int         STATE_W   = 4;
    localparam logic [3:0] STATE_RST = 4'h0;
    localparam logic [3:0] DEC_MAX   = 4'h9;
    localparam logic [3:0] BIN_MAX   = 4'hF;

    // ------------------------------------------------------------
    // Register bus map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  OFS_STATUS  = 4'h0;
    localparam logic [3:0]  OFS_CAPTURE = 4'h4;
    localparam int          ST_TC_BIT   = 4;
    localparam int          ST_DEC_BIT  = 5;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Synchronous control inputs, travelling together
    // ------------------------------------------------------------
    typedef struct packed {
        logic load_enable_n;
        logic parallel_count_enable;
        logic trickle_count_enable;
    } spc_ctrl_t;
endpackage

// file: sim/spc_counter_test.sv
// Self-checking bench for the presettable counter
`timescale 1ns/10ps
module spc_counter_test;
    logic               sys_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               master_clear_n = 1'b1;
    spc_pkg::spc_ctrl_t ctrl = 3'b100;
    logic [3:0]         preset_value = 4'h0;
    logic [3:0]         count_state;
    logic               terminal_flag;
    logic [3:0]         avs_address = 4'h0;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic [31:0]        avs_writedata = 32'h0000_0001;
    logic [3:0]         avs_byteenable = 4'hF;
    logic [3:0]         digit;
    logic [3:0]         digit_fast;
    logic [31:0]        rd;
    int                 fail_count = 0;
    int                 n_tests = 0;
    int                 cycles = 0;

    always #50 sys_clk = ~sys_clk;

    spc_counter u_spc_counter (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .master_clear_n(master_clear_n), .ctrl(ctrl),
        .preset_value(preset_value), .count_state(count_state),
        .terminal_flag(terminal_flag), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    // Slow cascade: flag into the next trickle enable
    spc_next_stage u_slow_stage (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .par_en(1'b1), .trk_en(terminal_flag), .digit(digit));
    // Fast cascade: flag into every parallel enable
    spc_next_stage u_fast_stage (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .par_en(terminal_flag), .trk_en(1'b1), .digit(digit_fast));

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic st(input logic [3:0] s, input logic f);
        chk("count_state", {28'h0, s}, {28'h0, count_state});
        chk("terminal_flag", {31'h0, f}, {31'h0, terminal_flag});
    endtask
    task automatic tick;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // Enables change just after the rising edge, so only while clock high
    // Edge-triggered build: enables may stand through the low phase
    task automatic drv(input spc_pkg::spc_ctrl_t c, input logic [3:0] p);
        @(posedge sys_clk);
        ctrl <= c;
        preset_value <= p;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fail_count++;
            stop_test;
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        tick;
        st(4'h0, 1'b0);
        drv(3'b111, 4'h0);
        for (int i = 1; i <= 10; i++) begin
            tick;
            st(4'(i % 10), i == 9);
        end
        chk("digit", 32'h1, {28'h0, digit});
        chk("digit_fast", 32'h1, {28'h0, digit_fast});
        $display("Test count done");
        drv(3'b011, 4'h9);
        tick;
        st(4'h9, 1'b1);
        drv(3'b110, 4'h0);
        tick;
        st(4'h9, 1'b0);
        drv(3'b101, 4'h0);
        tick;
        st(4'h9, 1'b1);
        bus(1'b0, spc_pkg::OFS_STATUS, 4'hF);
        chk("status", 32'h0000_0039, rd);
        bus(1'b1, spc_pkg::OFS_CAPTURE, 4'h0);
        bus(1'b0, spc_pkg::OFS_CAPTURE, 4'hF);
        chk("capture_lane", 32'h0000_0000, rd);
        bus(1'b1, spc_pkg::OFS_CAPTURE, 4'hF);
        bus(1'b0, spc_pkg::OFS_CAPTURE, 4'hF);
        chk("capture", 32'h0000_0009, rd);
        bus(1'b0, 4'h8, 4'hF);
        chk("unmapped", 32'h0000_0000, rd);
        $display("Test hold done");
        for (int p = 10; p <= 15; p++) begin
            drv(3'b011, 4'(p));
            tick;
            st(4'(p), 1'b0);
            drv(3'b111, 4'h0);
            tick;
            st(4'h0, 1'b0);
        end
        drv(3'b000, 4'h5);
        tick;
        st(4'h5, 1'b0);
        drv(3'b111, 4'h0);
        $display("Test illegal done");
        tick;
        @(posedge sys_clk);
        master_clear_n <= 1'b0;
        @(negedge sys_clk);
        st(4'h0, 1'b0);
        @(posedge sys_clk);
        master_clear_n <= 1'b1;
        tick;
        st(4'h1, 1'b0);
        $display("Test clear done");
        stop_test;
    end
endmodule

// file: sim/spc_next_stage.sv
// Next cascaded decade stage fed by the terminal flag
`timescale 1ns/10ps
module spc_next_stage (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Cascade enables and state
    input  wire logic       par_en,
    input  wire logic       trk_en,
    output logic [3:0]      digit
);
    // Flag is a synchronous enable here, never a clock: it may spike
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            digit <= 4'h0;
        end else if (par_en && trk_en) begin
            digit <= (digit == 4'h9) ? 4'h0 : digit + 4'h1;
        end
    end
endmodule
